// ===== hw/sdo_parameter_store.sv
// Expedited SDO interpreter with working copy and a parameter store kept over NMT resets but cleared by rstn
`timescale 1ns/10ps

module sdo_parameter_store
	import sdo_store_pkg::*;
#(
	parameter int STORE_BUSY_CYCLES = STORE_CYCLES
) (
	input  wire logic       clock,
	input  wire logic       rstn,
	input  wire logic       rx_valid,
	input  wire sdo_frame_t rx_frame,
	input  wire logic       nmt_valid,
	input  wire logic [7:0] nmt_command,
	input  wire logic [7:0] nmt_node,
	input  wire logic       store_disturbed,
	output logic            tx_valid,
	output sdo_frame_t      tx_frame,
	output logic            bootup_valid,
	output logic [10:0]     bootup_id,
	output logic            safety_frames_enable,
	output logic            store_busy,
	output logic [6:0]      node_number_field
);

	localparam logic [7:0] NMT_START      = 8'h01;
	localparam logic [7:0] NMT_STOP       = 8'h02;
	localparam logic [7:0] NMT_PREOP      = 8'h80;
	localparam logic [7:0] NMT_RESET_NODE = 8'h81;
	localparam logic [7:0] NMT_RESET_COMM = 8'h82;

	typedef enum logic [1:0] {
		ST_BOOT,
		ST_IDLE,
		ST_STORING
	} phase_t;

	typedef struct packed {
		phase_t                          phase;
		net_state_t                      net;
		logic [NUM_PARAMS-1:0][31:0]     work;
		logic [NUM_PARAMS-1:0][31:0]     nonvol;
		logic                            nonvol_ok;
		logic [31:0]                     busy_count;
		logic                            tx_valid;
		sdo_frame_t                      tx_frame;
		logic                            bootup_valid;
		logic [10:0]                     bootup_id;
		logic                            safety_en;
		logic [15:0]                     store_index;
		logic                            busy;
	} state_t;

	logic   rst_meta;
	logic   rst_sync;
	state_t s;
	state_t next_s;

	////////////////////////////////////////////////////////////////////////////
	// Reset release through two flops

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Store disturbance comes from outside the clock domain; two flops before use

	logic disturb_meta;
	logic disturb_sync;

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			disturb_meta <= 1'b0;
			disturb_sync <= 1'b0;
		end else begin
			disturb_meta <= store_disturbed;
			disturb_sync <= disturb_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Object lookup helpers

	function automatic logic [PARAM_BITS-1:0] slot_of(input logic [15:0] idx);
		logic [PARAM_BITS-1:0] r;
		r = 4'hf;
		unique case (idx)
			IDX_SYNC_ID:      r = 4'h0;
			IDX_HEARTBEAT:    r = 4'h1;
			IDX_OS_COMMAND:   r = 4'h2;
			IDX_ERROR_BEHAV:  r = 4'h3;
			IDX_FRAME_COMM:   r = 4'h4;
			IDX_FRAME_MAP:    r = 4'h5;
			IDX_CONFIG_VALID: r = 4'h6;
			IDX_CHECKSUM:     r = 4'h7;
			IDX_HYSTERESIS:   r = 4'h8;
			IDX_NODE_NUMBER:  r = 4'h9;
			IDX_BIT_RATE:     r = 4'ha;
			IDX_OPERATING:    r = 4'hb;
			IDX_RESOLUTION:   r = 4'hc;
			IDX_RANGE:        r = 4'hd;
			IDX_PRESET:       r = 4'he;
			default:          r = 4'hf;
		endcase
		return r;
	endfunction : slot_of

	// Safety objects may only be downloaded singly outside the operational state; a restore still sets them to defaults there
	function automatic logic is_safety(input logic [15:0] idx);
		logic r;
		r = 1'b0;
		unique case (idx)
			IDX_FRAME_COMM:   r = 1'b1;
			IDX_FRAME_MAP:    r = 1'b1;
			IDX_CONFIG_VALID: r = 1'b1;
			IDX_CHECKSUM:     r = 1'b1;
			IDX_OPERATING:    r = 1'b1;
			IDX_RESOLUTION:   r = 1'b1;
			IDX_RANGE:        r = 1'b1;
			IDX_PRESET:       r = 1'b1;
			default:          r = 1'b0;
		endcase
		return r;
	endfunction : is_safety

	// Same defaults for every encoder type, node number and bit rate included
	function automatic logic [NUM_PARAMS-1:0][31:0] defaults();
		logic [NUM_PARAMS-1:0][31:0] d;
		for (int i = 0; i < NUM_PARAMS; i++) begin
			d[i] = PARAM_DEFAULT;
		end
		d[0] = SYNC_DEFAULT;
		d[9] = {25'h0, NODE_DEFAULT};
		return d;
	endfunction : defaults

	// Value length in bytes of a download command; zero when the command is no download
	function automatic logic [7:0] download_len_ok(input logic [7:0] cmd);
		logic [7:0] r;
		r = 8'h00;
		unique case (cmd)
			CMD_DOWNLOAD_NS: r = 8'h04;
			CMD_DOWNLOAD_4:  r = 8'h04;
			CMD_DOWNLOAD_3:  r = 8'h03;
			CMD_DOWNLOAD_2:  r = 8'h02;
			CMD_DOWNLOAD_1:  r = 8'h01;
			default:         r = 8'h00;
		endcase
		return r;
	endfunction : download_len_ok

	// Size-indicated downloads of 3, 2 or 1 bytes carry fewer bytes; unused upper bytes are dropped
	function automatic logic [31:0] download_value(input logic [7:0] cmd, input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if (cmd == CMD_DOWNLOAD_3) begin
			r = {8'h00, v[23:0]};
		end else if (cmd == CMD_DOWNLOAD_2) begin
			r = {16'h0000, v[15:0]};
		end else if (cmd == CMD_DOWNLOAD_1) begin
			r = {24'h000000, v[7:0]};
		end
		return r;
	endfunction : download_value

	function automatic logic [7:0] upload_cmd(input logic [31:0] v);
		logic [7:0] r;
		if (v[31:24] != 8'h00) begin
			r = CMD_UPLOAD_4;
		end else if (v[23:16] != 8'h00) begin
			r = CMD_UPLOAD_3;
		end else if (v[15:8] != 8'h00) begin
			r = CMD_UPLOAD_2;
		end else begin
			r = CMD_UPLOAD_1;
		end
		return r;
	endfunction : upload_cmd

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [6:0]                  own_node;
	logic [PARAM_BITS-1:0]       slot;
	logic                        addressed;
	logic                        in_area;
	logic                        nmt_mine;
	logic                        nmt_reset;
	logic                        is_upload;
	logic                        is_download;
	logic                        store_ok;
	logic                        safety_refused;
	logic [NUM_PARAMS-1:0][31:0] boot_image;

	always_comb begin
		next_s = s;
		next_s.tx_valid = 1'b0;
		next_s.bootup_valid = 1'b0;
		own_node = s.work[9][6:0];
		slot = slot_of(rx_frame.index);
		addressed = rx_valid && (rx_frame.id == (ID_REQUEST_BASE + {4'h0, own_node}));
		in_area = (rx_frame.index >= IDX_COMM_LO) && (rx_frame.index <= IDX_PROFILE_HI);
		nmt_mine = nmt_valid && ((nmt_node == 8'h00) || (nmt_node == {1'b0, own_node}));
		nmt_reset = nmt_mine && ((nmt_command == NMT_RESET_NODE) || (nmt_command == NMT_RESET_COMM));
		is_upload = (rx_frame.command == CMD_UPLOAD_REQ);
		is_download = (download_len_ok(rx_frame.command) != 8'h00) && in_area;
		store_ok = (rx_frame.subindex == STORE_SUBINDEX) && (rx_frame.value == STORE_SIGNATURE);
		safety_refused = (s.net == NET_OPERATIONAL) && is_safety(rx_frame.index);
		// Image chosen once so the boot-up identifier and the working copy agree
		boot_image = s.nonvol_ok ? s.nonvol : defaults();
		next_s.tx_frame.id = ID_RESPONSE_BASE + {4'h0, own_node};
		unique case (s.phase)
			ST_BOOT: begin
				// Stored values become active here; a damaged image gives defaults
				next_s.work = boot_image;
				next_s.net = NET_PREOP;
				next_s.bootup_valid = 1'b1;
				next_s.bootup_id = ID_BOOTUP_BASE + {4'h0, boot_image[9][6:0]};
				next_s.phase = ST_IDLE;
			end
			ST_IDLE: begin
				if (nmt_mine) begin
					if (nmt_command == NMT_START) begin
						next_s.net = NET_OPERATIONAL;
					end else if (nmt_command == NMT_STOP) begin
						next_s.net = NET_STOPPED;
					end else if (nmt_command == NMT_PREOP) begin
						next_s.net = NET_PREOP;
					end else if ((nmt_command == NMT_RESET_NODE) || (nmt_command == NMT_RESET_COMM)) begin
						next_s.phase = ST_BOOT;
					end
				end else if (addressed && (s.net != NET_STOPPED)) begin
					next_s.tx_valid = 1'b1;
					next_s.tx_frame.index = rx_frame.index;
					next_s.tx_frame.subindex = rx_frame.subindex;
					next_s.tx_frame.value = 32'h0;
					next_s.tx_frame.command = CMD_WARNING;
					if (is_upload) begin
						if (rx_frame.index == IDX_SW_VERSION) begin
							next_s.tx_frame.command = upload_cmd(SW_VERSION);
							next_s.tx_frame.value = SW_VERSION;
						end else if (slot != 4'hf) begin
							next_s.tx_frame.command = upload_cmd(s.work[slot]);
							next_s.tx_frame.value = s.work[slot];
						end
					end else if (is_download) begin
						if (safety_refused) begin
							next_s.tx_frame.value = ABORT_SAFETY_OP;
						end else if (rx_frame.index == IDX_STORE) begin
							if (store_ok) begin
								// Reply held back until the write is done
								next_s.tx_valid = 1'b0;
								next_s.phase = ST_STORING;
								next_s.busy_count = STORE_BUSY_CYCLES;
								next_s.nonvol_ok = 1'b0;
								next_s.store_index = rx_frame.index;
							end
						end else if (rx_frame.index == IDX_RESTORE) begin
							next_s.work = defaults();
							next_s.tx_frame.command = CMD_DOWNLOAD_ACK;
						end else if (slot != 4'hf) begin
							next_s.work[slot] = download_value(rx_frame.command, rx_frame.value);
							next_s.tx_frame.command = CMD_DOWNLOAD_ACK;
						end
					end
				end
			end
			ST_STORING: begin
				// Requests and NMT commands other than a reset are ignored now; a disturbance leaves the image invalid
				// Either reset mid-write would leave a half-written image, so it counts as a disturbance
				if (disturb_sync || nmt_reset) begin
					next_s.phase = ST_BOOT;
				end else if (s.busy_count > 32'd1) begin
					next_s.busy_count = s.busy_count - 32'd1;
				end else begin
					next_s.nonvol = s.work;
					next_s.nonvol_ok = 1'b1;
					next_s.phase = ST_IDLE;
					next_s.tx_valid = 1'b1;
					next_s.tx_frame.command = CMD_DOWNLOAD_ACK;
					next_s.tx_frame.index = s.store_index;
					next_s.tx_frame.subindex = STORE_SUBINDEX;
					next_s.tx_frame.value = 32'h0;
				end
			end
		endcase
		// Frames run only when operational with configuration valid set
		next_s.safety_en = (next_s.net == NET_OPERATIONAL) && next_s.work[6][0];
		// Kept as a flop so the busy output needs no decode after the register
		next_s.busy = (next_s.phase == ST_STORING);
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clock or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs, each straight from a state flop

	assign tx_valid             = s.tx_valid;
	assign tx_frame             = s.tx_frame;
	assign bootup_valid         = s.bootup_valid;
	assign bootup_id            = s.bootup_id;
	assign safety_frames_enable = s.safety_en;
	assign store_busy           = s.busy;
	assign node_number_field    = s.work[9][6:0];

endmodule : sdo_parameter_store

// ===== hw/sdo_store_pkg.sv
// Package of constants and carriers for the SDO parameter store
package sdo_store_pkg;

	localparam logic [7:0]  CMD_DOWNLOAD_NS   = 8'h22;
	localparam logic [7:0]  CMD_DOWNLOAD_4    = 8'h23;
	localparam logic [7:0]  CMD_DOWNLOAD_3    = 8'h27;
	localparam logic [7:0]  CMD_DOWNLOAD_2    = 8'h2b;
	localparam logic [7:0]  CMD_DOWNLOAD_1    = 8'h2f;
	localparam logic [7:0]  CMD_DOWNLOAD_ACK  = 8'h60;
	localparam logic [7:0]  CMD_UPLOAD_REQ    = 8'h40;
	localparam logic [7:0]  CMD_UPLOAD_4      = 8'h43;
	localparam logic [7:0]  CMD_UPLOAD_3      = 8'h47;
	localparam logic [7:0]  CMD_UPLOAD_2      = 8'h4b;
	localparam logic [7:0]  CMD_UPLOAD_1      = 8'h4f;
	localparam logic [7:0]  CMD_WARNING       = 8'h80;

	localparam logic [10:0] ID_REQUEST_BASE   = 11'h600;
	localparam logic [10:0] ID_RESPONSE_BASE  = 11'h580;
	localparam logic [10:0] ID_BOOTUP_BASE    = 11'h700;

	localparam logic [15:0] IDX_COMM_LO       = 16'h1000;
	localparam logic [15:0] IDX_COMM_HI       = 16'h1fff;
	localparam logic [15:0] IDX_MAKER_LO      = 16'h2000;
	localparam logic [15:0] IDX_MAKER_HI      = 16'h5fff;
	localparam logic [15:0] IDX_PROFILE_LO    = 16'h6000;
	localparam logic [15:0] IDX_PROFILE_HI    = 16'h9fff;

	localparam logic [15:0] IDX_SYNC_ID       = 16'h1005;
	localparam logic [15:0] IDX_SW_VERSION    = 16'h100a;
	localparam logic [15:0] IDX_STORE         = 16'h1010;
	localparam logic [15:0] IDX_RESTORE       = 16'h1011;
	localparam logic [15:0] IDX_HEARTBEAT     = 16'h1017;
	localparam logic [15:0] IDX_OS_COMMAND    = 16'h1023;
	localparam logic [15:0] IDX_ERROR_BEHAV   = 16'h1029;
	localparam logic [15:0] IDX_FRAME_COMM    = 16'h1301;
	localparam logic [15:0] IDX_FRAME_MAP     = 16'h1381;
	localparam logic [15:0] IDX_CONFIG_VALID  = 16'h13fe;
	localparam logic [15:0] IDX_CHECKSUM      = 16'h13ff;
	localparam logic [15:0] IDX_HYSTERESIS    = 16'h2003;
	localparam logic [15:0] IDX_NODE_NUMBER   = 16'h3000;
	localparam logic [15:0] IDX_BIT_RATE      = 16'h3001;
	localparam logic [15:0] IDX_OPERATING     = 16'h6000;
	localparam logic [15:0] IDX_RESOLUTION    = 16'h6001;
	localparam logic [15:0] IDX_RANGE         = 16'h6002;
	localparam logic [15:0] IDX_PRESET        = 16'h6003;

	localparam logic [7:0]  STORE_SUBINDEX    = 8'h01;
	localparam logic [31:0] STORE_SIGNATURE   = 32'h65766173;
	localparam logic [31:0] ABORT_SAFETY_OP   = 32'h08000022;

	localparam int          NUM_PARAMS        = 15;
	localparam int          PARAM_BITS        = 4;
	localparam int          STORE_TIME_MS     = 1000;
	localparam int          CLOCK_MHZ         = 100;
	localparam int          STORE_CYCLES      = STORE_TIME_MS * 1000 * CLOCK_MHZ;

	localparam logic [6:0]  NODE_DEFAULT      = 7'h01;
	localparam logic [31:0] PARAM_DEFAULT     = 32'h00000000;
	localparam logic [31:0] SYNC_DEFAULT      = 32'h80000080;
	localparam logic [31:0] SW_VERSION        = 32'h00010000;

	typedef enum logic [1:0] {
		NET_INIT,
		NET_PREOP,
		NET_OPERATIONAL,
		NET_STOPPED
	} net_state_t;

	typedef struct packed {
		logic [10:0] id;
		logic [7:0]  command;
		logic [15:0] index;
		logic [7:0]  subindex;
		logic [31:0] value;
	} sdo_frame_t;

endpackage : sdo_store_pkg

// ===== sim/sdo_store_checker_asserts.sv
// Port-level checks of the SDO parameter store
`timescale 1ns/10ps
module sdo_store_checker
	import sdo_store_pkg::*;
#(
	parameter int STORE_BUSY_CYCLES = STORE_CYCLES
) (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic        rx_valid,
	input wire sdo_frame_t  rx_frame,
	input wire logic        nmt_valid,
	input wire logic [7:0]  nmt_command,
	input wire logic [7:0]  nmt_node,
	input wire logic        store_disturbed,
	input wire logic        tx_valid,
	input wire sdo_frame_t  tx_frame,
	input wire logic        bootup_valid,
	input wire logic [10:0] bootup_id,
	input wire logic        safety_frames_enable,
	input wire logic        store_busy,
	input wire logic [6:0]  node_number_field
);
	int busy_cnt;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// Counts sampled busy cycles of the current store
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn)
			busy_cnt <= 0;
		else
			busy_cnt <= store_busy ? busy_cnt + 1 : 0;
	end
	////////////////////////////////////////
	a_reply_id: assert property (tx_valid |-> tx_frame.id == ID_RESPONSE_BASE + {4'h0, node_number_field})
		else $error("reply id wrong");
	a_store_len: assert property ($fell(store_busy) && tx_valid |-> busy_cnt == STORE_BUSY_CYCLES)
		else $error("store time wrong");
	a_no_early: assert property (store_busy |-> !tx_valid)
		else $error("reply during store");
	a_boot_id: assert property (bootup_valid |-> bootup_id == ID_BOOTUP_BASE + {4'h0, node_number_field})
		else $error("boot id wrong");
	a_upload_size: assert property (tx_valid && tx_frame.command[7:4] == 4'h4 |-> tx_frame.command ==
		(tx_frame.value[31:24] != 8'h00 ? CMD_UPLOAD_4 : tx_frame.value[23:16] != 8'h00 ? CMD_UPLOAD_3 :
		tx_frame.value[15:8] != 8'h00 ? CMD_UPLOAD_2 : CMD_UPLOAD_1))
		else $error("upload size code wrong");
	a_frames_start: assert property ($rose(safety_frames_enable) |-> $past(nmt_valid) || $past(nmt_valid, 2))
		else $error("frames without start");
	a_store_cause: assert property ($rose(store_busy) |-> $past(rx_valid) && $past(rx_frame.index) == IDX_STORE)
		else $error("store without request");
	a_reply_echo: assert property (tx_valid && !$past(store_busy) |-> $past(rx_valid) &&
		tx_frame.index == $past(rx_frame.index))
		else $error("reply not tied to request");
endmodule : sdo_store_checker

bind sdo_parameter_store sdo_store_checker #(.STORE_BUSY_CYCLES(STORE_BUSY_CYCLES)) i_sdo_store_checker (
	.clock(clock), .rstn(rstn), .rx_valid(rx_valid), .rx_frame(rx_frame), .nmt_valid(nmt_valid),
	.nmt_command(nmt_command), .nmt_node(nmt_node), .store_disturbed(store_disturbed), .tx_valid(tx_valid),
	.tx_frame(tx_frame), .bootup_valid(bootup_valid), .bootup_id(bootup_id),
	.safety_frames_enable(safety_frames_enable), .store_busy(store_busy), .node_number_field(node_number_field));

// ===== sim/sdo_master_model.sv
// Network master model issuing expedited SDO requests
`timescale 1ns/10ps
module sdo_master_model
	import sdo_store_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       tx_valid,
	input  wire sdo_frame_t tx_frame,
	output logic            rx_valid,
	output sdo_frame_t      rx_frame
);
	initial begin
		rx_valid = 1'b0;
		rx_frame = '0;
	end
	// Blocks until the reply or for at most 64 cycles, so no other request or command goes out meanwhile
	task automatic xfer(input logic [7:0] c, input logic [15:0] i, input logic [7:0] s, input logic [31:0] v,
		output sdo_frame_t rsp, output logic got);
		int n;
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_frame <= '{ID_REQUEST_BASE + 11'h001, c, i, s, v};
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_frame <= ~rx_frame;
		got = 1'b0;
		for (n = 0; n < 64 && !got; n++) begin
			#1;
			if (tx_valid === 1'b1) begin
				got = 1'b1;
				rsp = tx_frame;
			end else
				@(posedge clock);
		end
	endtask : xfer
endmodule : sdo_master_model

// ===== sim/tb_sdo_parameter_store.sv
// Self-checking bench for the SDO parameter store
`timescale 1ns/10ps
module tb_sdo_parameter_store
	import sdo_store_pkg::*;
;
	localparam int BUSY = 20;
	logic		clock, rstn, rx_valid, nmt_valid, store_disturbed, tx_valid, bootup_valid, safety_frames_enable, store_busy;
	logic [7:0]	nmt_command, nmt_node;
	logic [10:0]	bootup_id;
	logic [6:0]	node_number_field;
	sdo_frame_t	rx_frame, tx_frame, rsp;
	int		error_cnt, check_count;

	sdo_parameter_store #(.STORE_BUSY_CYCLES(BUSY)) i_sdo_parameter_store (.clock(clock), .rstn(rstn),
		.rx_valid(rx_valid), .rx_frame(rx_frame), .nmt_valid(nmt_valid), .nmt_command(nmt_command),
		.nmt_node(nmt_node), .store_disturbed(store_disturbed), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.bootup_valid(bootup_valid), .bootup_id(bootup_id), .safety_frames_enable(safety_frames_enable),
		.store_busy(store_busy), .node_number_field(node_number_field));
	sdo_master_model i_sdo_master_model (.clock(clock), .tx_valid(tx_valid), .tx_frame(tx_frame),
		.rx_valid(rx_valid), .rx_frame(rx_frame));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic req(input logic [7:0] c, input logic [15:0] i, input logic [31:0] v, input logic [7:0] ec);
		logic got;
		i_sdo_master_model.xfer(c, i, (i == IDX_STORE || i == IDX_RESTORE) ? 8'h01 : 8'h00, v, rsp, got);
		chk({31'h0, got}, 32'h1, "no reply");
		chk({24'h0, rsp.command}, {24'h0, ec}, "reply command");
		chk({21'h0, rsp.id}, 32'h581, "reply id");
	endtask : req

	task automatic nmt(input logic [7:0] c, input logic [7:0] n);
		@(posedge clock);
		nmt_valid <= 1'b1;
		nmt_command <= c;
		nmt_node <= n;
		@(posedge clock);
		nmt_valid <= 1'b0;
	endtask : nmt

	task automatic boot_wait;
		int n;
		for (n = 0; n < 20 && bootup_valid !== 1'b1; n++) begin
			@(posedge clock);
			#1;
		end
		chk({31'h0, bootup_valid}, 32'h1, "no boot-up");
		chk({21'h0, bootup_id}, 32'h701, "boot-up id");
	endtask : boot_wait

	task automatic t_rw;
		logic [7:0]	dc [5];
		logic [7:0]	uc [5];
		logic [31:0]	mk [5];
		dc = '{8'h22, 8'h23, 8'h27, 8'h2b, 8'h2f};
		uc = '{8'h43, 8'h43, 8'h47, 8'h4b, 8'h4f};
		mk = '{32'hffffffff, 32'hffffffff, 32'h00ffffff, 32'h0000ffff, 32'h000000ff};
		for (int k = 0; k < 5; k++) begin
			req(dc[k], IDX_PRESET, 32'h11223344, CMD_DOWNLOAD_ACK);
			req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, uc[k]);
			chk(rsp.value, 32'h11223344 & mk[k], "read back");
		end
		req(CMD_UPLOAD_REQ, IDX_SW_VERSION, 32'h0, CMD_UPLOAD_3);
		chk(rsp.value, SW_VERSION, "version");
		req(CMD_UPLOAD_REQ, 16'h6004, 32'h0, CMD_WARNING);
		req(CMD_DOWNLOAD_NS, IDX_STORE, 32'h12345678, CMD_WARNING);
		$display("read/write test done");
	endtask : t_rw

	task automatic t_op;
		logic got;
		req(CMD_DOWNLOAD_NS, IDX_CONFIG_VALID, 32'h1, CMD_DOWNLOAD_ACK);
		chk({31'h0, safety_frames_enable}, 32'h0, "frames in preop");
		nmt(8'h01, 8'h01);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, safety_frames_enable}, 32'h1, "no frames");
		req(CMD_DOWNLOAD_NS, IDX_PRESET, 32'h5, CMD_WARNING);
		chk(rsp.value, ABORT_SAFETY_OP, "abort code");
		req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, 32'h44, "read while operational");
		nmt(8'h02, 8'h01);
		i_sdo_master_model.xfer(CMD_UPLOAD_REQ, IDX_PRESET, 8'h00, 32'h0, rsp, got);
		chk({31'h0, got}, 32'h0, "reply while stopped");
		nmt(8'h80, 8'h00);
		repeat (3) @(posedge clock);
		#1;
		chk({31'h0, safety_frames_enable}, 32'h0, "frames after preop");
		$display("state test done");
	endtask : t_op

	task automatic t_persist;
		time t0;
		req(CMD_DOWNLOAD_1, IDX_PRESET, 32'h55, CMD_DOWNLOAD_ACK);
		t0 = $time;
		req(CMD_DOWNLOAD_NS, IDX_STORE, STORE_SIGNATURE, CMD_DOWNLOAD_ACK);
		chk({31'h0, ($time - t0) >= BUSY * 10}, 32'h1, "store too quick");
		req(CMD_DOWNLOAD_1, IDX_PRESET, 32'h77, CMD_DOWNLOAD_ACK);
		req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, 32'h77, "working copy");
		nmt(8'h81, 8'h01);
		boot_wait();
		req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, 32'h55, "stored value");
		$display("store test done");
	endtask : t_persist

	task automatic t_disturb;
		logic got;
		req(CMD_DOWNLOAD_1, IDX_PRESET, 32'h99, CMD_DOWNLOAD_ACK);
		fork
			i_sdo_master_model.xfer(CMD_DOWNLOAD_NS, IDX_STORE, 8'h01, STORE_SIGNATURE, rsp, got);
			begin
				repeat (6) @(posedge clock);
				chk({31'h0, store_busy}, 32'h1, "not busy while storing");
				store_disturbed <= 1'b1;
				@(posedge clock);
				store_disturbed <= 1'b0;
			end
		join
		chk({31'h0, got}, 32'h0, "reply to broken store");
		nmt(8'h82, 8'h01);
		boot_wait();
		req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, PARAM_DEFAULT, "default after broken store");
		$display("disturb test done");
	endtask : t_disturb

	task automatic t_restore;
		req(CMD_DOWNLOAD_NS, IDX_SYNC_ID, 32'h181, CMD_DOWNLOAD_ACK);
		req(CMD_DOWNLOAD_1, IDX_PRESET, 32'h5a, CMD_DOWNLOAD_ACK);
		req(CMD_DOWNLOAD_NS, IDX_BIT_RATE, 32'h3, CMD_DOWNLOAD_ACK);
		req(CMD_DOWNLOAD_NS, IDX_RESTORE, 32'h64616f6c, CMD_DOWNLOAD_ACK);
		req(CMD_UPLOAD_REQ, IDX_PRESET, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, PARAM_DEFAULT, "preset default");
		req(CMD_UPLOAD_REQ, IDX_SYNC_ID, 32'h0, CMD_UPLOAD_4);
		chk(rsp.value, SYNC_DEFAULT, "sync default");
		req(CMD_UPLOAD_REQ, IDX_NODE_NUMBER, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, {25'h0, NODE_DEFAULT}, "node default");
		req(CMD_UPLOAD_REQ, IDX_BIT_RATE, 32'h0, CMD_UPLOAD_1);
		chk(rsp.value, PARAM_DEFAULT, "bit rate default");
		chk({25'h0, node_number_field}, {25'h0, NODE_DEFAULT}, "node field");
		$display("restore test done");
	endtask : t_restore

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// Whole sequence needs a few hundred cycles; allow ten thousand
	initial begin
		#100000;
		error_cnt++;
		test_done();
	end

	initial begin
		error_cnt = 0;
		check_count = 0;
		rstn = 1'b0;
		nmt_valid = 1'b0;
		nmt_command = 8'h00;
		nmt_node = 8'h01;
		store_disturbed = 1'b0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		boot_wait();
		t_rw();
		t_op();
		t_persist();
		t_disturb();
		t_restore();
		test_done();
	end
endmodule : tb_sdo_parameter_store
